// >>> rtl/mem_type_msr_pkg.sv
/*
  Package for the memory-type and interrupt-controller model-specific register bank:
  register indices, field positions, reset values and memory-type encodings.
  Assumes it is compiled before any module that imports it.
*/
package mem_type_msr_pkg;

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [31:0] IDX_INTC_BASE      = 32'h0000001B;
  localparam logic [31:0] IDX_CLUSTER_ID     = 32'h0000002A;
  localparam logic [31:0] IDX_FIXED_F8000    = 32'h0000026F;
  localparam logic [31:0] IDX_PAGE_ATTR      = 32'h00000277;
  localparam logic [31:0] IDX_DEF_TYPE       = 32'h000002FF;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int DEF_GLOBAL_EN_BIT  = 11;
  localparam int DEF_FIXED_EN_BIT   = 10;
  localparam int INTC_ENABLE_BIT    = 11;
  localparam int INTC_BOOTSTRAP_BIT = 8;
  localparam int INTC_BASE_LSB      = 12;
  localparam int INTC_BASE_MSB      = 39;
  localparam int CLUSTER_LSB        = 16;

  // bits that may be written as one; any other set bit faults
  localparam logic [63:0] PAT_WRITABLE  = 64'h0707070707070707;
  localparam logic [63:0] DEF_WRITABLE  = 64'h0000000000000CFF;
  localparam logic [63:0] INTC_WRITABLE = 64'h000000FFFFFFF900;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [63:0] PAT_RESET       = 64'h0007040600070406;
  localparam logic [27:0] INTC_BASE_RESET = 28'h00FEE00;
  localparam logic [63:0] DEF_RESET       = 64'h0000000000000000;
  localparam logic [63:0] FIXED_RESET     = 64'h0000000000000000;

  // ----------------------------------------------------------------------
  // defined memory-type encodings: 0, 1, 4, 5, 6, and 7 for the page table only
  // ----------------------------------------------------------------------
  localparam logic [7:0] MT_UNCACHEABLE   = 8'h00;
  localparam logic [7:0] MT_COMBINING     = 8'h01;
  localparam logic [7:0] MT_WRITETHROUGH  = 8'h04;
  localparam logic [7:0] MT_WRITEPROTECT  = 8'h05;
  localparam logic [7:0] MT_WRITEBACK     = 8'h06;
  localparam logic [7:0] MT_UC_MINUS      = 8'h07;

  // ----------------------------------------------------------------------
  // access operation
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } msr_op_t;

endpackage

// >>> rtl/mem_type_msrs.sv
/*
  Register bank of 64-bit model-specific registers: top fixed-range memory types,
  page-attribute table, default-type control, interrupt-controller base and the
  read-only cluster-ID register. Software reaches them through one read or write
  request per cycle with a register index; each request is answered one cycle later
  with done, read data, and a general-protection fault flag (error code zero).
  Register map, by index:
    0x01B  interrupt-controller base address, enable and bootstrap flag
    0x02A  power-on cluster ID, read-only
    0x26F  memory types of the eight 4 KiB pages from F8000 to FFFFF
    0x277  page-attribute table, eight 3-bit types
    0x2FF  default memory type and the two range enables
  Any other index faults on read and on write; a faulted write changes nothing.
  The decoded outputs follow the registers one cycle after a write lands.
  Assumes the requester shares clk and holds each request for one cycle. The
  strap pins are levels from outside the clock domain, steady from before reset
  release; the bootstrap strap is caught at the first edge after release, so an
  interrupt-controller write taken at that very edge is dropped.
*/
`timescale 1ns/1ps
`default_nettype none

module mem_type_msrs
  import mem_type_msr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // straps
  input  wire logic        bootstrap_strap,
  input  wire logic [1:0]  cluster_strap,
  // register access
  input  wire logic        msr_rd,
  input  wire logic        msr_wr,
  input  wire logic [31:0] msr_index,
  input  wire logic [63:0] msr_wdata,
  output logic             msr_done,
  output logic [63:0]      msr_rdata,
  output logic             msr_gp_fault,
  // decoded controls toward the memory-typing logic and the interrupt controller
  output logic [63:0]      fixed_types_f8000,
  output logic [63:0]      page_attr_types,
  output logic             range_regs_global_enable,
  output logic             fixed_ranges_enable,
  output logic [7:0]       default_memory_type,
  output logic [27:0]      intc_base_address,
  output logic             intc_enable,
  output logic             intc_bootstrap
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // defined memory types for range registers; 7 is only defined for page attributes
  function automatic logic type_ok(input logic [7:0] t, input logic page_attribute_table);
    type_ok = (t == MT_UNCACHEABLE) || (t == MT_COMBINING) ||
              (t == MT_WRITETHROUGH) || (t == MT_WRITEPROTECT) ||
              (t == MT_WRITEBACK) || (page_attribute_table && (t == MT_UC_MINUS));
  endfunction

  // every byte of a 64-bit value must be a defined type
  function automatic logic all_types_ok(input logic [63:0] v, input logic page_attribute_table);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      ok = ok & type_ok(v[8*i +: 8], page_attribute_table);
    end
    all_types_ok = ok;
  endfunction

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [63:0] fixed_reg;       // bytes page_type_f8 .. page_type_ff
  logic [63:0] pat_reg;         // attr_index0_type .. attr_index7_type
  logic [63:0] def_reg;
  logic [27:0] base_reg;
  logic        en_reg;
  logic        bsp_reg;
  logic [1:0]  cluster_reg;
  logic        strap_seen;

  // ----------------------------------------------------------------------
  // decode and checks
  // ----------------------------------------------------------------------
  wire logic hit_fixed   = (msr_index == IDX_FIXED_F8000);
  wire logic hit_pat     = (msr_index == IDX_PAGE_ATTR);
  wire logic hit_def     = (msr_index == IDX_DEF_TYPE);
  wire logic hit_intc    = (msr_index == IDX_INTC_BASE);
  wire logic hit_cluster = (msr_index == IDX_CLUSTER_ID);
  wire logic hit_any     = hit_fixed | hit_pat | hit_def | hit_intc | hit_cluster;

  // reserved-bit checks
  wire logic pat_rsvd_bad  = |(msr_wdata & ~PAT_WRITABLE);
  wire logic def_rsvd_bad  = |(msr_wdata & ~DEF_WRITABLE);
  wire logic intc_rsvd_bad = |(msr_wdata & ~INTC_WRITABLE);

  // memory-type checks
  wire logic fixed_type_bad = !all_types_ok(msr_wdata, 1'b0);
  wire logic pat_type_bad   = !all_types_ok(msr_wdata, 1'b1);
  wire logic def_type_bad   = !type_ok(msr_wdata[7:0], 1'b0);

  // write fault: unmapped index, read-only target, or bad content
  wire logic wr_fault = !hit_any
                      | hit_cluster
                      | (hit_fixed & fixed_type_bad)
                      | (hit_pat & (pat_rsvd_bad | pat_type_bad))
                      | (hit_def & (def_rsvd_bad | def_type_bad))
                      | (hit_intc & intc_rsvd_bad);
  wire logic wr_ok    = msr_wr & !wr_fault;
  wire logic rd_fault = !hit_any;
  wire logic wr_bad   = msr_wr & wr_fault;
  wire logic rd_ok    = msr_rd & !msr_wr & !rd_fault;                   // a write wins over a read
  wire logic rd_bad   = msr_rd & !msr_wr & rd_fault;

  // write strobes, one per writable register, for accepted writes only
  wire logic wr_fixed = wr_ok & hit_fixed;
  wire logic wr_pat   = wr_ok & hit_pat;
  wire logic wr_def   = wr_ok & hit_def;
  wire logic wr_intc  = wr_ok & hit_intc;

  // assembled interrupt-controller base value
  wire logic [63:0] intc_value = {24'h000000, base_reg, en_reg, 2'b00, bsp_reg, 8'h00};

  // assembled cluster value, ID in bits 17-16
  wire logic [63:0] cluster_value = 64'(cluster_reg) << CLUSTER_LSB;

  // read mux
  wire logic [63:0] next_rdata =
      hit_fixed   ? fixed_reg :
      hit_pat     ? pat_reg :
      hit_def     ? def_reg :
      hit_intc    ? intc_value :
      hit_cluster ? cluster_value :
                    64'h0000000000000000;

  // ----------------------------------------------------------------------
  // named fields of the stored registers
  // ----------------------------------------------------------------------

  // one memory type per 4 KiB page
  wire logic [7:0] page_type_f8 = fixed_reg[7:0];
  wire logic [7:0] page_type_f9 = fixed_reg[15:8];
  wire logic [7:0] page_type_fa = fixed_reg[23:16];
  wire logic [7:0] page_type_fb = fixed_reg[31:24];
  wire logic [7:0] page_type_fc = fixed_reg[39:32];
  wire logic [7:0] page_type_fd = fixed_reg[47:40];
  wire logic [7:0] page_type_fe = fixed_reg[55:48];
  wire logic [7:0] page_type_ff = fixed_reg[63:56];

  // one memory type per attribute index; the upper five bits of each byte stay zero
  wire logic [2:0] attr_index0_type = pat_reg[2:0];
  wire logic [2:0] attr_index1_type = pat_reg[10:8];
  wire logic [2:0] attr_index2_type = pat_reg[18:16];
  wire logic [2:0] attr_index3_type = pat_reg[26:24];
  wire logic [2:0] attr_index4_type = pat_reg[34:32];
  wire logic [2:0] attr_index5_type = pat_reg[42:40];
  wire logic [2:0] attr_index6_type = pat_reg[50:48];
  wire logic [2:0] attr_index7_type = pat_reg[58:56];

  // default-type fields
  wire logic       range_enable_field = def_reg[DEF_GLOBAL_EN_BIT];
  wire logic       fixed_enable_field = def_reg[DEF_FIXED_EN_BIT];
  wire logic [7:0] default_type_field = def_reg[7:0];

  // ----------------------------------------------------------------------
  // straps, caught one clock after reset release
  // ----------------------------------------------------------------------
  logic bsp_meta;
  logic bsp_sync;
  logic [1:0] cl_meta;
  logic [1:0] cl_sync;

  // two-flop synchronisers for the strap pins; kept out of reset so that
  // they already hold the strap levels when reset is released
  always_ff @(posedge clk) begin
    bsp_meta <= bootstrap_strap;
    bsp_sync <= bsp_meta;
    cl_meta  <= cluster_strap;
    cl_sync  <= cl_meta;
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------

  // fixed-range fields: no architectural reset value, cleared for determinism
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fixed_reg <= FIXED_RESET;
    end else if (wr_fixed) begin
      fixed_reg <= msr_wdata;
    end
  end

  // page-attribute table
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pat_reg <= PAT_RESET;
    end else if (wr_pat) begin
      pat_reg <= msr_wdata;
    end
  end

  // default type and enables
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      def_reg <= DEF_RESET;
    end else if (wr_def) begin
      def_reg <= msr_wdata;
    end
  end

  // interrupt-controller base, enable and bootstrap flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_reg   <= INTC_BASE_RESET;
      en_reg     <= 1'b0;
      bsp_reg    <= 1'b0;
      strap_seen <= 1'b0;
    end else if (!strap_seen) begin
      bsp_reg    <= bsp_sync;
      strap_seen <= 1'b1;
    end else if (wr_intc) begin
      base_reg <= msr_wdata[INTC_BASE_MSB:INTC_BASE_LSB];
      en_reg   <= msr_wdata[INTC_ENABLE_BIT];
      bsp_reg  <= msr_wdata[INTC_BOOTSTRAP_BIT];
    end
  end

  // read-only cluster ID follows the synchronised strap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cluster_reg <= 2'h0;
    end else begin
      cluster_reg <= cl_sync;
    end
  end

  // ----------------------------------------------------------------------
  // answer to each request
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msr_done     <= 1'b0;
      msr_rdata    <= 64'h0000000000000000;
      msr_gp_fault <= 1'b0;
    end else begin
      msr_done     <= msr_rd | msr_wr;
      msr_rdata    <= rd_ok ? next_rdata : 64'h0000000000000000;
      msr_gp_fault <= wr_bad | rd_bad;
    end
  end

  // ----------------------------------------------------------------------
  // decoded outputs, registered
  // ----------------------------------------------------------------------

  // memory-type controls toward the memory-typing logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fixed_types_f8000        <= FIXED_RESET;
      page_attr_types          <= PAT_RESET;
      range_regs_global_enable <= 1'b0;
      fixed_ranges_enable      <= 1'b0;
      default_memory_type      <= 8'h00;
    end else begin
      fixed_types_f8000        <= {page_type_ff, page_type_fe, page_type_fd, page_type_fc,
                                   page_type_fb, page_type_fa, page_type_f9, page_type_f8};
      page_attr_types          <= {5'h00, attr_index7_type, 5'h00, attr_index6_type,
                                   5'h00, attr_index5_type, 5'h00, attr_index4_type,
                                   5'h00, attr_index3_type, 5'h00, attr_index2_type,
                                   5'h00, attr_index1_type, 5'h00, attr_index0_type};
      range_regs_global_enable <= range_enable_field;
      fixed_ranges_enable      <= fixed_enable_field;
      default_memory_type      <= default_type_field;
    end
  end

  // interrupt-controller controls
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intc_base_address        <= INTC_BASE_RESET;
      intc_enable              <= 1'b0;
      intc_bootstrap           <= 1'b0;
    end else begin
      intc_base_address        <= base_reg;
      intc_enable              <= en_reg;
      intc_bootstrap           <= bsp_reg;
    end
  end

endmodule // mem_type_msrs

`default_nettype wire

// >>> tb/mem_type_msrs_asserts.sv
/* concurrent checks on the msr bank ports.
   assumes one clock, sys_rst async high; bound to mem_type_msrs below */
`timescale 1ns/1ps
`default_nettype none
module mem_type_msrs_asserts
  import mem_type_msr_pkg::*;
(
  // watched ports
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        msr_rd,
  input wire logic        msr_wr,
  input wire logic [31:0] msr_index,
  input wire logic [63:0] msr_wdata,
  input wire logic        msr_done,
  input wire logic [63:0] msr_rdata,
  input wire logic        msr_gp_fault,
  input wire logic [63:0] fixed_types_f8000,
  input wire logic [63:0] page_attr_types,
  input wire logic [27:0] intc_base_address,
  input wire logic        intc_enable
);
  // request decodes
  wire logic req  = msr_rd | msr_wr;
  wire logic w_fx = msr_wr && msr_index == IDX_FIXED_F8000;
  wire logic w_pa = msr_wr && msr_index == IDX_PAGE_ATTR;
  wire logic w_df = msr_wr && msr_index == IDX_DEF_TYPE;
  wire logic w_ic = msr_wr && msr_index == IDX_INTC_BASE;
  wire logic a_cl = msr_index == IDX_CLUSTER_ID;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  answer_timing_a: assert property (req |=> msr_done)
    else $error("request not answered");
  quiet_idle_a: assert property (!req |=> !msr_done && !msr_gp_fault && msr_rdata == 64'h0)
    else $error("answer without request");
  attr_resv_a: assert property (w_pa && |(msr_wdata & ~PAT_WRITABLE) |=> msr_gp_fault)
    else $error("attr reserved bit accepted");
  def_resv_a: assert property (w_df && |(msr_wdata & ~DEF_WRITABLE) |=> msr_gp_fault)
    else $error("default reserved bit accepted");
  intc_resv_a: assert property (w_ic && |(msr_wdata & ~INTC_WRITABLE) |=> msr_gp_fault)
    else $error("intc reserved bit accepted");
  cluster_ro_a: assert property (msr_wr && a_cl |=> msr_gp_fault)
    else $error("cluster write accepted");
  cluster_read_a: assert property (msr_rd && !msr_wr && a_cl |=>
    (msr_rdata & ~64'h30000) == 64'h0)
    else $error("cluster read bad bits");
  fixed_load_a: assert property (w_fx ##1 !msr_gp_fault |=>
    fixed_types_f8000 == $past(msr_wdata, 2))
    else $error("fixed types not loaded");
  attr_keep_a: assert property (w_pa ##1 msr_gp_fault |=> $stable(page_attr_types))
    else $error("faulted write changed attr");
  reset_load_a: assert property ($fell(sys_rst) |->
    page_attr_types == PAT_RESET && intc_base_address == INTC_BASE_RESET && !intc_enable)
    else $error("bad reset values");
  // main scenarios
  cover property (w_fx ##1 !msr_gp_fault);
  cover property (w_pa ##1 msr_gp_fault);
  cover property (msr_rd && a_cl);
endmodule // mem_type_msrs_asserts
bind mem_type_msrs mem_type_msrs_asserts u_mem_type_msrs_asserts (
  .clk(clk), .sys_rst(sys_rst), .msr_rd(msr_rd), .msr_wr(msr_wr), .msr_index(msr_index),
  .msr_wdata(msr_wdata), .msr_done(msr_done), .msr_rdata(msr_rdata), .msr_gp_fault(msr_gp_fault),
  .fixed_types_f8000(fixed_types_f8000), .page_attr_types(page_attr_types),
  .intc_base_address(intc_base_address), .intc_enable(intc_enable));
`default_nettype wire

// >>> tb/testbench.sv
/* self-checking bench for the msr bank: register accesses and readback.
   assumes the package is compiled first and the checker is bound */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mem_type_msr_pkg::*;
  logic        clk = 0, sys_rst = 1, bootstrap_strap = 1, msr_rd = 0, msr_wr = 0;
  logic [1:0]  cluster_strap = 2'h2;
  logic [31:0] msr_index = 32'h0;
  logic [63:0] msr_wdata = 64'h0, v;
  wire logic   msr_done, msr_gp_fault, rg_en, fx_en, ic_en, ic_bs;
  wire logic [63:0] msr_rdata, fx_t, pa_t;
  wire logic [7:0]  df_t;
  wire logic [27:0] ic_b;
  int          failures = 0, cmp_count = 0;
  localparam logic [63:0] FX = 64'h0605040100060504, PA = 64'h0001040506070006;
  localparam logic [63:0] BAD = 64'h0203070810FF8009, IC = 64'h0000000ABCDEF900;
  always #5 clk = ~clk;
  mem_type_msrs u_mem_type_msrs (
    .clk(clk), .sys_rst(sys_rst), .bootstrap_strap(bootstrap_strap), .cluster_strap(cluster_strap),
    .msr_rd(msr_rd), .msr_wr(msr_wr), .msr_index(msr_index), .msr_wdata(msr_wdata),
    .msr_done(msr_done), .msr_rdata(msr_rdata), .msr_gp_fault(msr_gp_fault),
    .fixed_types_f8000(fx_t), .page_attr_types(pa_t), .range_regs_global_enable(rg_en),
    .fixed_ranges_enable(fx_en), .default_memory_type(df_t), .intc_base_address(ic_b),
    .intc_enable(ic_en), .intc_bootstrap(ic_bs));
  // ------------------------------------------------------------
  // compare, access and closing tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request; checks fault flag and, for reads, data
  task automatic xfer(input logic wr, input logic [31:0] idx, input logic [63:0] wd,
                      input logic ef, input logic [63:0] er);
    int n;
    @(posedge clk);
    msr_rd <= !wr;
    msr_wr <= wr;
    msr_index <= idx;
    msr_wdata <= wd;
    @(posedge clk);
    msr_rd <= 1'b0;
    msr_wr <= 1'b0;
    // answer stands for one cycle; look just after the edge that launched it
    #1;
    for (n = 0; n < 4 && msr_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 4) begin
      chk("timeout", 64'h0, 64'h1);
      end_of_test();
    end else begin
      chk("fault", {63'h0, ef}, {63'h0, msr_gp_fault});
      if (!wr) chk("rdata", er, msr_rdata);
    end
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    xfer(0, IDX_PAGE_ATTR, 0, 0, PAT_RESET);
    xfer(0, IDX_DEF_TYPE, 0, 0, DEF_RESET);
    xfer(0, IDX_INTC_BASE, 0, 0, {24'h0, INTC_BASE_RESET, 12'h100});
    xfer(0, IDX_CLUSTER_ID, 0, 0, 64'h20000);
    xfer(1, IDX_CLUSTER_ID, 64'h0, 1, 0);
    xfer(1, IDX_FIXED_F8000, FX, 0, 0);
    xfer(1, IDX_PAGE_ATTR, PA, 0, 0);
    for (int k = 0; k < 8; k++) begin
      v = FX;
      v[8*k +: 8] = BAD[8*k +: 8];
      xfer(1, IDX_FIXED_F8000, v, 1, 0);
      v = PA;
      v[8*k +: 3] = 3'h2 + 3'(k % 2);
      xfer(1, IDX_PAGE_ATTR, v, 1, 0);
      v = PA;
      v[8*k + 3 + k % 5] = 1'b1;
      xfer(1, IDX_PAGE_ATTR, v, 1, 0);
    end
    xfer(0, IDX_FIXED_F8000, 0, 0, FX);
    xfer(0, IDX_PAGE_ATTR, 0, 0, PA);
    chk("fixed_types", FX, fx_t);
    chk("attr_types", PA, pa_t);
    xfer(1, IDX_DEF_TYPE, 64'hC05, 0, 0);
    xfer(1, IDX_DEF_TYPE, 64'h100, 1, 0);
    xfer(1, IDX_DEF_TYPE, 64'h1000, 1, 0);
    xfer(1, IDX_DEF_TYPE, 64'h807, 1, 0);
    xfer(0, IDX_DEF_TYPE, 0, 0, 64'hC05);
    chk("def_outputs", 64'hC05, {52'h0, rg_en, fx_en, 2'h0, df_t});
    xfer(1, IDX_INTC_BASE, IC, 0, 0);
    xfer(1, IDX_INTC_BASE, IC | 64'h10000000000, 1, 0);
    xfer(1, IDX_INTC_BASE, IC | 64'h200, 1, 0);
    xfer(1, IDX_INTC_BASE, IC | 64'h1, 1, 0);
    xfer(0, IDX_INTC_BASE, 0, 0, IC);
    chk("intc_outputs", {34'h0, IC[39:12], 2'h3}, {34'h0, ic_b, ic_en, ic_bs});
    // second reset in mid-run: attribute, default and interrupt-controller registers must return to reset values
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    xfer(0, IDX_PAGE_ATTR, 0, 0, PAT_RESET);
    xfer(0, IDX_DEF_TYPE, 0, 0, DEF_RESET);
    xfer(0, IDX_INTC_BASE, 0, 0, {24'h0, INTC_BASE_RESET, 12'h100});
    chk("rst_ic", {34'h0, INTC_BASE_RESET, 2'h1}, {34'h0, ic_b, ic_en, ic_bs});
    chk("rst_def", 64'h0, {52'h0, rg_en, fx_en, 2'h0, df_t});
    chk("rst_attr", PAT_RESET, pa_t);
    xfer(0, 32'h00000250, 0, 1, 0);
    xfer(1, 32'h00000250, 64'h6, 1, 0);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
